// ===== cbm_consts.vh
// Constants for the coherent bus memory slave.
// Assumes it is included by its bare name from the memory slave design file.
`ifndef CBM_CONSTS_VH
`define CBM_CONSTS_VH
// Address phase field positions on the shared lines
`define CBM_IDX_LSB 3
`define CBM_IDX_MSB 10
`define CBM_OFF_MSB 2
`define CBM_TYPE_LSB 36
`define CBM_TYPE_MSB 39
`define CBM_SIZE_LSB 40
`define CBM_SIZE_MSB 42
// Transaction type codes
`define CBM_T_WRITE 4'h0
`define CBM_T_READ 4'h1
`define CBM_T_CINV 4'h2
`define CBM_T_CREAD 4'h3
`define CBM_T_CWINV 4'h4
`define CBM_T_CRINV 4'h5
// Transfer size codes
`define CBM_SZ_1B 3'h0
`define CBM_SZ_2B 3'h1
`define CBM_SZ_4B 3'h2
`define CBM_SZ_8B 3'h3
`define CBM_SZ_32B 3'h4
`define CBM_BURST_BEATS 3'h4
// Register byte offsets
`define CBM_REG_CTRL 8'h00
`define CBM_REG_CRLAT 8'h04
`define CBM_REG_CILAT 8'h08
`define CBM_REG_STATUS 8'h0C
`define CBM_REG_MASK 8'h10
`define CBM_REG_STATE 8'h14
// Control bits and reset values
`define CBM_CTRL_INV_EN 0
`define CBM_CTRL_ERR_RETRY 1
`define CBM_CTRL_ERR_LATE 2
`define CBM_CTRL_INJECT 3
`define CBM_CTRL_RST 4'h1
`define CBM_CRLAT_RST 8'h03
`define CBM_CILAT_RST 8'h02
// Status bits
`define CBM_EV_ABORT 0
`define CBM_EV_INV 1
`define CBM_EV_ERR 2
// Cycle counts measured from the address strobe cycle
`define CBM_WR_LAT 8'h01
`define CBM_RD_LAT 8'h02
`define CBM_CI_LAT_MIN 8'h02
`define CBM_CR_LAT_MIN 8'h03
`define CBM_ERR_LAT 8'h02
`endif

// ===== cbm_lat_cnt.v
// Cycle counter measured from the address strobe cycle.
// Assumes start is a one-cycle pulse in the strobe cycle.
`timescale 1ns/1ps
module cbm_lat_cnt (
	input wire clk,
	input wire resetn,
	input wire start,
	output reg [7:0] cnt_r
);
	////////////////////////////////////////////////////////////////////////
	// Counts k in cycle A+k, saturating at the top
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
		end else if (start) begin
			cnt_r <= 8'h01;
		end else if (cnt_r != 8'hFF) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule // cbm_lat_cnt

// ===== cbm_wrap_idx.v
// Word index of a burst beat, wrapping inside the 32-byte block.
// Assumes four doublewords per block.
`timescale 1ns/1ps
module cbm_wrap_idx (
	input wire [7:0] base_idx,
	input wire [2:0] beat,
	output wire [7:0] idx
);
	// Low two bits advance from the requested word and wrap
	assign idx = {base_idx[7:2], base_idx[1:0] + beat[1:0]};
endmodule // cbm_wrap_idx

// ===== cbm_mem_slave.v
// Memory slave on a circuit-switched cache-coherent processor bus.
// Assumes bus inputs are synchronous to clk and open-drain lines
// are resolved outside from the output enables.
//
// Behaviour
// - Never relinquish-and-retry; plain retry allowed
// - Wrapped bursts start at requested word
// - Support every defined transfer size
// - Decode only type and size fields
// - Coherent types act as plain read/write
// - Intervention aborts coherent reads at once
// - Acknowledge every coherent invalidate
// - Control bit disables invalidate acknowledge
// - Invalidate acknowledge no earlier than A+2
// - Programmable invalidate acknowledge delay
// - Shared snoop response is ignored
// - Write-and-invalidate equals plain write
// - Programmable minimum coherent read latency
// - Hold bad data back until checked
// - Slave only, no arbitration signals
// - No coherent read ack before intervention
// - Release data lines on intervention
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cbm_consts.vh"
module cbm_mem_slave (
	input wire clk,
	input wire resetn,
	input wire addr_strobe_n,
	input wire [63:0] addr_data_lines,
	input wire cache_intervene_n,
	output reg [63:0] addr_data_out_r,
	output reg addr_data_oe_r,
	output reg data_ready_ack_n_r,
	output reg data_ready_oe_r,
	output reg retry_ack_n_r,
	output reg retry_oe_r,
	output reg error_ack_n_r,
	output reg error_oe_r,
	output reg async_error_n_r,
	output reg async_error_oe_r,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_r,
	output reg irq_r
);
	////////////////////////////////////////////////////////////////////////
	// One-hot transaction states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_WR = 4'b0010;
	localparam [3:0] ST_RD = 4'b0100;
	localparam [3:0] ST_ONE = 4'b1000;
	// Single acknowledge kinds
	localparam K_READY = 1'b0;
	localparam K_ERROR = 1'b1;

	reg [3:0] state_r;
	reg [3:0] type_r;
	reg [2:0] size_r;
	reg [7:0] base_r;
	reg [2:0] off_r;
	reg [2:0] beat_r;
	reg [2:0] nbeats_r;
	reg [7:0] lat_r;
	reg coh_r;
	reg kind_r;
	reg [3:0] ctrl_r;
	reg [7:0] crlat_r;
	reg [7:0] cilat_r;
	reg [2:0] status_r;
	reg [2:0] status_nxt;
	reg [2:0] mask_r;
	reg [2:0] ev;
	reg [63:0] mem [0:255];
	reg par_mem [0:255];
	reg [7:0] lat_sel;
	reg [3:0] st_sel;
	reg [2:0] nb_sel;
	reg k_sel;
	reg c_sel;

	wire [7:0] cnt;
	wire start;
	wire lat_ok;
	wire [3:0] a_type;
	wire [2:0] a_size;
	wire [2:0] beat_sel;
	wire [7:0] idx;
	wire [63:0] rword;
	wire rbad;
	wire [7:0] lanes;
	wire [63:0] bmask;
	wire [63:0] merged;
	wire abort;
	wire [7:0] cr_eff;
	wire [7:0] ci_eff;

	////////////////////////////////////////////////////////////////////////
	// Address phase decode; other multiplexed fields unused
	assign a_type = addr_data_lines[`CBM_TYPE_MSB:`CBM_TYPE_LSB];
	assign a_size = addr_data_lines[`CBM_SIZE_MSB:`CBM_SIZE_LSB];
	assign start = state_r[0] && !addr_strobe_n;

	// Cycle count since the strobe cycle
	cbm_lat_cnt u_cnt (
		.clk(clk),
		.resetn(resetn),
		.start(start),
		.cnt_r(cnt)
	);

	// An action set now shows in the next cycle, so compare with cnt+1
	assign lat_ok = ({1'b0, cnt} + 9'h001) >= {1'b0, lat_r};

	// Clamp programmed delays to their floors
	assign ci_eff = (cilat_r < `CBM_CI_LAT_MIN) ? `CBM_CI_LAT_MIN :
		cilat_r;
	assign cr_eff = (crlat_r < `CBM_CR_LAT_MIN) ? `CBM_CR_LAT_MIN :
		crlat_r;

	////////////////////////////////////////////////////////////////////////
	// Beat word index; a write stores the beat whose ready shows this cycle
	assign beat_sel = (state_r[1] && data_ready_oe_r) ?
		(beat_r - 3'h1) : beat_r;

	cbm_wrap_idx u_wrap (
		.base_idx(base_r),
		.beat(beat_sel),
		.idx(idx)
	);

	// Stored word and its check bit
	assign rword = mem[idx];
	assign rbad = (^rword) != par_mem[idx];

	// Intervention only matters for coherent reads
	assign abort = state_r[2] && coh_r && !cache_intervene_n;

	////////////////////////////////////////////////////////////////////////
	// Byte lanes of a partial write
	function [7:0] lane_mask;
		input [2:0] sz;
		input [2:0] off;
		begin
			case (sz)
				`CBM_SZ_1B: lane_mask = 8'h01 << off;
				`CBM_SZ_2B: lane_mask = 8'h03 << off;
				`CBM_SZ_4B: lane_mask = 8'h0F << off;
				default: lane_mask = 8'hFF;
			endcase
		end
	endfunction

	assign lanes = lane_mask(size_r, off_r);

	// Expand lane bits to a bit mask
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_lane
			assign bmask[8*g+7:8*g] = {8{lanes[g]}};
		end
	endgenerate

	assign merged = (rword & ~bmask) | (addr_data_lines & bmask);

	////////////////////////////////////////////////////////////////////////
	// Classify a new request in the strobe cycle
	always @* begin
		st_sel = ST_ONE;
		lat_sel = `CBM_ERR_LAT;
		nb_sel = 3'h1;
		k_sel = K_ERROR;
		c_sel = 1'b0;
		if (a_size == `CBM_SZ_32B) begin
			nb_sel = `CBM_BURST_BEATS;
		end
		if (a_size <= `CBM_SZ_32B) begin
			case (a_type)
				`CBM_T_WRITE, `CBM_T_CWINV: begin
					st_sel = ST_WR;
					lat_sel = `CBM_WR_LAT;
				end
				`CBM_T_READ: begin
					st_sel = ST_RD;
					lat_sel = `CBM_RD_LAT;
				end
				`CBM_T_CREAD, `CBM_T_CRINV: begin
					st_sel = ST_RD;
					lat_sel = cr_eff;
					c_sel = 1'b1;
				end
				`CBM_T_CINV: begin
					k_sel = K_READY;
					lat_sel = ci_eff;
					if (!ctrl_r[`CBM_CTRL_INV_EN]) begin
						st_sel = ST_IDLE;
					end
				end
				default: begin
					st_sel = ST_ONE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transaction engine; shared snoop and arbitration lines have no port
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			type_r <= 4'h0;
			size_r <= 3'h0;
			base_r <= 8'h00;
			off_r <= 3'h0;
			beat_r <= 3'h0;
			nbeats_r <= 3'h0;
			lat_r <= 8'h00;
			coh_r <= 1'b0;
			kind_r <= K_READY;
			ev <= 3'h0;
			addr_data_out_r <= 64'h0000000000000000;
			addr_data_oe_r <= 1'b0;
			data_ready_ack_n_r <= 1'b1;
			data_ready_oe_r <= 1'b0;
			retry_ack_n_r <= 1'b1;
			retry_oe_r <= 1'b0;
			error_ack_n_r <= 1'b1;
			error_oe_r <= 1'b0;
			async_error_n_r <= 1'b1;
			async_error_oe_r <= 1'b0;
		end else begin
			// Every line is released unless a state drives it
			ev <= 3'h0;
			addr_data_oe_r <= 1'b0;
			data_ready_ack_n_r <= 1'b1;
			data_ready_oe_r <= 1'b0;
			retry_ack_n_r <= 1'b1;
			retry_oe_r <= 1'b0;
			error_ack_n_r <= 1'b1;
			error_oe_r <= 1'b0;
			async_error_n_r <= 1'b1;
			async_error_oe_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= st_sel;
						type_r <= a_type;
						size_r <= a_size;
						base_r <= addr_data_lines[`CBM_IDX_MSB:`CBM_IDX_LSB];
						off_r <= addr_data_lines[`CBM_OFF_MSB:0];
						beat_r <= 3'h0;
						nbeats_r <= nb_sel;
						lat_r <= lat_sel;
						coh_r <= c_sel;
						kind_r <= k_sel;
						if (a_type == `CBM_T_CINV && st_sel == ST_IDLE) begin
							kind_r <= K_READY;
						end
					end
				end
				ST_WR: begin
					// Store the beat whose ready shows this cycle
					if (data_ready_oe_r) begin
						mem[idx] <= merged;
						par_mem[idx] <= (^merged) ^ ctrl_r[`CBM_CTRL_INJECT];
					end
					if (beat_r < nbeats_r && lat_ok) begin
						data_ready_ack_n_r <= 1'b0;
						data_ready_oe_r <= 1'b1;
						beat_r <= beat_r + 3'h1;
					end else if (beat_r == nbeats_r && data_ready_oe_r) begin
						state_r <= ST_IDLE;
					end
				end
				ST_RD: begin
					if (abort) begin
						// Stop at once and free the lines for the owner
						ev[`CBM_EV_ABORT] <= 1'b1;
						addr_data_oe_r <= 1'b0;
						state_r <= ST_IDLE;
					end else if (beat_r == nbeats_r) begin
						state_r <= ST_IDLE;
					end else if (lat_ok) begin
						if (rbad && !ctrl_r[`CBM_CTRL_ERR_LATE]) begin
							// Bad word never reaches the bus
							ev[`CBM_EV_ERR] <= 1'b1;
							if (ctrl_r[`CBM_CTRL_ERR_RETRY]) begin
								retry_ack_n_r <= 1'b0;
								retry_oe_r <= 1'b1;
							end else begin
								error_ack_n_r <= 1'b0;
								error_oe_r <= 1'b1;
							end
							state_r <= ST_IDLE;
						end else begin
							addr_data_out_r <= rword;
							addr_data_oe_r <= 1'b1;
							data_ready_ack_n_r <= 1'b0;
							data_ready_oe_r <= 1'b1;
							beat_r <= beat_r + 3'h1;
							if (rbad) begin
								// Late report on the asynchronous line
								ev[`CBM_EV_ERR] <= 1'b1;
								async_error_n_r <= 1'b0;
								async_error_oe_r <= 1'b1;
							end
						end
					end
				end
				ST_ONE: begin
					if (lat_ok) begin
						if (kind_r == K_READY) begin
							data_ready_ack_n_r <= 1'b0;
							data_ready_oe_r <= 1'b1;
							ev[`CBM_EV_INV] <= 1'b1;
						end else begin
							error_ack_n_r <= 1'b0;
							error_oe_r <= 1'b1;
							ev[`CBM_EV_ERR] <= 1'b1;
						end
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky status; an event in the clearing read cycle survives
	always @* begin
		status_nxt = status_r;
		if (reg_rd && reg_addr == `CBM_REG_STATUS) begin
			status_nxt = 3'h0;
		end
		status_nxt = status_nxt | ev;
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes, status and interrupt
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= `CBM_CTRL_RST;
			crlat_r <= `CBM_CRLAT_RST;
			cilat_r <= `CBM_CILAT_RST;
			mask_r <= 3'h0;
			status_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r <= |(status_nxt & mask_r);
			if (reg_wr) begin
				case (reg_addr)
					`CBM_REG_CTRL: ctrl_r <= reg_wdata[3:0];
					`CBM_REG_CRLAT: crlat_r <= reg_wdata[7:0];
					`CBM_REG_CILAT: cilat_r <= reg_wdata[7:0];
					`CBM_REG_MASK: mask_r <= reg_wdata[2:0];
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data stands in the cycle after the read strobe only
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_r <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`CBM_REG_CTRL: reg_rdata_r <= {28'h0000000, ctrl_r};
				`CBM_REG_CRLAT: reg_rdata_r <= {24'h000000, crlat_r};
				`CBM_REG_CILAT: reg_rdata_r <= {24'h000000, cilat_r};
				`CBM_REG_STATUS: reg_rdata_r <= {29'h00000000, status_r};
				`CBM_REG_MASK: reg_rdata_r <= {29'h00000000, mask_r};
				`CBM_REG_STATE: reg_rdata_r <= {20'h00000, beat_r[1:0],
					size_r, type_r[2:0], state_r};
				default: reg_rdata_r <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_r <= 32'h00000000;
		end
	end
endmodule // cbm_mem_slave

// ===== cbm_slave_chk_asserts.sv
// Checker on the memory slave acknowledge timing.
// Assumes it is bound into cbm_mem_slave; one clock, reset low.
`timescale 1ns/1ps
module cbm_slave_chk (
	input wire clk,
	input wire resetn,
	input wire addr_strobe_n,
	input wire [63:0] addr_data_lines,
	input wire cache_intervene_n,
	input wire addr_data_oe_r,
	input wire data_ready_ack_n_r,
	input wire data_ready_oe_r,
	input wire retry_oe_r,
	input wire error_ack_n_r,
	input wire error_oe_r
);
	// Address phase fields
	wire go = !addr_strobe_n;
	wire [3:0] ty = addr_data_lines[39:36];
	wire [2:0] sz = addr_data_lines[42:40];
	wire crd = go && (ty == 4'h3 || ty == 4'h5);
	wire wrt = go && (ty == 4'h0 || ty == 4'h4) && sz == 3'h3;
	wire rd8 = go && ty == 4'h1 && sz == 3'h3;
	wire rdb = go && ty == 4'h1 && sz == 3'h4;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	////////////////
	// Acknowledge timing counted from the strobe cycle
	AST_CI_LATE: assert property (go && ty == 4'h2 |=> !data_ready_oe_r)
		else $error("invalidate ack before A+2");
	AST_CR_FLOOR: assert property (crd |=> !data_ready_oe_r [*2])
		else $error("coherent read ack before A+3");
	AST_WR_ACK: assert property (
		wrt |=> !data_ready_oe_r ##1 !data_ready_ack_n_r
		##1 !data_ready_oe_r)
		else $error("write ack not at A+2 only");
	AST_RD_ACK: assert property (
		rd8 |=> !data_ready_oe_r ##1 addr_data_oe_r && !data_ready_ack_n_r)
		else $error("read data not at A+2");
	AST_BURST: assert property (
		rdb |-> ##2 addr_data_oe_r [*4] ##1 !addr_data_oe_r)
		else $error("burst read not four beats");
	// Intervention releases the data and ready lines for three cycles
	AST_ABORT: assert property (
		!cache_intervene_n |=> (!addr_data_oe_r && !data_ready_oe_r) [*3])
		else $error("lines held after intervention");
	AST_ONE_ACK: assert property (
		data_ready_oe_r |-> !retry_oe_r && !error_oe_r)
		else $error("two acks at once");
	AST_RSV_ERR: assert property (
		go && sz == 3'h5 |=> !error_oe_r ##1 error_oe_r && !error_ack_n_r)
		else $error("reserved size not refused at A+2");
endmodule // cbm_slave_chk

bind cbm_mem_slave cbm_slave_chk u_chk (.clk(clk), .resetn(resetn),
	.addr_strobe_n(addr_strobe_n), .addr_data_lines(addr_data_lines),
	.cache_intervene_n(cache_intervene_n),
	.addr_data_oe_r(addr_data_oe_r),
	.data_ready_ack_n_r(data_ready_ack_n_r),
	.data_ready_oe_r(data_ready_oe_r), .retry_oe_r(retry_oe_r),
	.error_ack_n_r(error_ack_n_r), .error_oe_r(error_oe_r));

// ===== cbm_bus_model.sv
// Bus master and snooping cache model facing the memory slave.
// Assumes one clock; the testbench calls op one transfer at a time.
`timescale 1ns/1ps
module cbm_bus_model (
	input wire clk,
	input wire [63:0] rd_data,
	input wire rd_oe,
	input wire rdy_n,
	input wire rdy_oe,
	output reg strobe_n,
	output reg [63:0] lines,
	output reg intervene_n
);
	reg [63:0] wd [0:3];
	reg [63:0] got [$];
	integer acks;
	integer first;
	// Idle bus at time zero
	initial begin
		strobe_n = 1'b1;
		lines = 64'h0;
		intervene_n = 1'b1;
	end
	////////////////
	// Strobe at A, then eleven cycles of write data or snoop response
	task automatic op(input [3:0] t, input [2:0] sz, input [10:0] a,
		input integer iv);
		integer n;
		integer b;
		begin
			got.delete();
			acks = 0;
			first = 0;
			b = 0;
			// Let the previous transfer's release settle for one edge
			@(posedge clk);
			strobe_n <= 1'b0;
			lines <= {21'h0, sz, t, 25'h0, a};
			for (n = 1; n < 12; n = n + 1) begin
				@(posedge clk);
				if (rdy_oe && !rdy_n) begin
					if (acks == 0)
						first = n - 1;
					acks = acks + 1;
					b = b + 1;
					if (rd_oe)
						got.push_back(rd_data);
				end
				strobe_n <= 1'b1;
				intervene_n <= (n != iv);
				// Released lines toggle so stale data cannot match
				lines <= (t == 4'h0 || t == 4'h4) ? wd[b[1:0]] : ~lines;
			end
		end
	endtask
endmodule // cbm_bus_model

// ===== test_coherent_bus_memory_slave.sv
// Testbench for the coherent bus memory slave.
// Assumes design, checker and bus model are compiled first.
`timescale 1ns/1ps
module test_coherent_bus_memory_slave;
	reg clk;
	reg resetn;
	reg [7:0] reg_addr;
	reg [31:0] reg_wdata;
	reg reg_wr;
	reg reg_rd;
	wire [31:0] reg_rdata_r;
	wire irq_r;
	wire addr_strobe_n;
	wire [63:0] addr_data_lines;
	wire cache_intervene_n;
	wire [63:0] addr_data_out_r;
	wire addr_data_oe_r;
	wire data_ready_ack_n_r;
	wire data_ready_oe_r;
	wire retry_ack_n_r;
	wire retry_oe_r;
	wire error_ack_n_r;
	wire error_oe_r;
	wire async_error_n_r;
	wire async_error_oe_r;
	integer n_ret = 0;
	integer n_err = 0;
	integer n_async_error_n = 0;
	integer n_mismatch = 0;
	integer checks_done = 0;
	integer cyc = 0;
	integer i;
	cbm_mem_slave uut (.clk(clk), .resetn(resetn),
		.addr_strobe_n(addr_strobe_n), .addr_data_lines(addr_data_lines),
		.cache_intervene_n(cache_intervene_n),
		.addr_data_out_r(addr_data_out_r), .addr_data_oe_r(addr_data_oe_r),
		.data_ready_ack_n_r(data_ready_ack_n_r),
		.data_ready_oe_r(data_ready_oe_r),
		.retry_ack_n_r(retry_ack_n_r), .retry_oe_r(retry_oe_r),
		.error_ack_n_r(error_ack_n_r), .error_oe_r(error_oe_r),
		.async_error_n_r(async_error_n_r),
		.async_error_oe_r(async_error_oe_r),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.irq_r(irq_r));
	cbm_bus_model m (.clk(clk), .rd_data(addr_data_out_r),
		.rd_oe(addr_data_oe_r), .rdy_n(data_ready_ack_n_r),
		.rdy_oe(data_ready_oe_r), .strobe_n(addr_strobe_n),
		.lines(addr_data_lines), .intervene_n(cache_intervene_n));
	////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			give_verdict;
		end
	end
	// Count retry, error and late error pulses as the master sees them
	always @(posedge clk) begin
		if (retry_oe_r && !retry_ack_n_r)
			n_ret = n_ret + 1;
		if (error_oe_r && !error_ack_n_r)
			n_err = n_err + 1;
		if (async_error_oe_r && !async_error_n_r)
			n_async_error_n = n_async_error_n + 1;
	end
	////////////////
	// Comparison, register access and closing report
	task chk(input [63:0] seen, input [63:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	task rw(input [7:0] a, input [31:0] v);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rc(input [7:0] a, input [31:0] v);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata_r, v);
		end
	endtask
	task give_verdict;
		begin
			$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	////////////////
	// Main sequence
	initial begin
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		for (i = 0; i < 4; i = i + 1)
			m.wd[i] = 64'h0123_4567_89AB_CD00 + i;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rc(8'h00, 32'h1);
		rc(8'h04, 32'h3);
		rc(8'h08, 32'h2);
		rc(8'h20, 32'h0);
		// Burst write, then wrapped burst read from word 2
		m.op(4'h0, 3'h4, {8'h08, 3'h0}, 0);
		chk(m.acks, 4);
		m.op(4'h1, 3'h4, {8'h0A, 3'h0}, 0);
		for (i = 0; i < 4; i = i + 1)
			chk(m.got[i], m.wd[(i + 2) % 4]);
		// Write-and-invalidate, byte merge, plain and coherent reads
		m.wd[0] = 64'hFEDC_BA98_7654_3210;
		m.op(4'h4, 3'h3, {8'h14, 3'h0}, 0);
		m.op(4'h1, 3'h3, {8'h14, 3'h0}, 0);
		chk(m.got[0], 64'hFEDC_BA98_7654_3210);
		m.wd[0] = 64'h0000_AB00_0000_0000;
		m.op(4'h0, 3'h0, {8'h14, 3'h5}, 0);
		m.op(4'h3, 3'h3, {8'h14, 3'h0}, 0);
		chk(m.got[0], 64'hFEDC_AB98_7654_3210);
		chk(m.first, 3);
		rw(8'h04, 32'h6);
		m.op(4'h5, 3'h3, {8'h14, 3'h0}, 0);
		chk(m.first, 6);
		rw(8'h04, 32'h3);
		// Invalidates: default delay, longer delay, disabled
		m.op(4'h2, 3'h3, {8'h14, 3'h0}, 0);
		chk(m.first, 2);
		chk(m.acks, 1);
		rw(8'h08, 32'h5);
		m.op(4'h2, 3'h3, {8'h14, 3'h0}, 0);
		chk(m.first, 5);
		rw(8'h00, 32'h0);
		m.op(4'h2, 3'h3, {8'h14, 3'h0}, 0);
		chk(m.acks, 0);
		rw(8'h00, 32'h1);
		chk(irq_r, 1'b0);
		rc(8'h0C, 32'h2);
		// Intervention aborts and raises the unmasked interrupt
		rw(8'h10, 32'h1);
		m.op(4'h3, 3'h4, {8'h08, 3'h0}, 4);
		chk(m.got.size(), 2);
		chk(irq_r, 1'b1);
		rc(8'h0C, 32'h1);
		@(posedge clk);
		#1 chk(irq_r, 1'b0);
		m.op(4'h5, 3'h4, {8'h08, 3'h0}, 2);
		chk(m.acks, 0);
		// Bad check bit: error ack, then retry ack, then late delivery
		rw(8'h00, 32'h9);
		m.op(4'h0, 3'h3, {8'h20, 3'h0}, 0);
		rw(8'h00, 32'h1);
		m.op(4'h1, 3'h2, {8'h20, 3'h0}, 0);
		chk(m.got.size(), 0);
		chk(n_err, 1);
		rw(8'h00, 32'h3);
		m.op(4'h1, 3'h2, {8'h20, 3'h0}, 0);
		chk(n_ret, 1);
		chk(m.acks, 0);
		rw(8'h00, 32'h5);
		m.op(4'h1, 3'h2, {8'h20, 3'h0}, 0);
		chk(m.got[0], m.wd[0]);
		chk(n_async_error_n, 1);
		rw(8'h00, 32'h1);
		// Reserved size gets no ready
		m.op(4'h1, 3'h5, 11'h000, 0);
		chk(m.acks, 0);
		chk(n_err, 2);
		rc(8'h0C, 32'h5);
		give_verdict;
	end
endmodule // test_coherent_bus_memory_slave
